// >>> shared/rmsm_pkg.sv
// shared constants, types and register layout of the radio mode controller
package rmsm_pkg;
    // ------------------------------------------------------------------
    // clock and sequence timing (times in ns)
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS   = 10;
    localparam int unsigned T_POR_NS        = 16000000; // shutdown exit, before idle-side steps
    localparam int unsigned T_XTAL_NS       = 600000;   // crystal start-up
    localparam int unsigned T_VCO_CAL_NS    = 100000;   // bias settling plus vco calibration
    localparam int unsigned T_PLL_SETTLE_NS = 95000;    // pll settling
    localparam int unsigned T_FRONT_END_NS  = 5000;     // pa ramp or receive chain start
    localparam int unsigned POR_CYC       = (T_POR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned XTAL_CYC      = (T_XTAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned VCO_CAL_CYC   = (T_VCO_CAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned PLL_SET_CYC   = (T_PLL_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned FRONT_END_CYC = (T_FRONT_END_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned TMR_W         = 21;

    // ------------------------------------------------------------------
    // register map (7-bit spi address)
    // ------------------------------------------------------------------
    localparam logic [6:0] ADDR_STATUS   = 7'h02;
    localparam logic [6:0] ADDR_MODE     = 7'h07;
    localparam logic [6:0] ADDR_CAL_CTRL = 7'h55;
    localparam logic [6:0] ADDR_XTAL_CTL = 7'h62;
    localparam logic [7:0] MODE_RST      = 8'h01; // ready: crystal on
    localparam logic [7:0] CAL_CTRL_RST  = 8'h00; // calibration not skipped
    localparam logic [7:0] XTAL_CTL_RST  = 8'h00;
    // mode control fields
    localparam int unsigned MODE_XTON  = 0;
    localparam int unsigned MODE_PLLON = 1;
    localparam int unsigned MODE_RXON  = 2;
    localparam int unsigned MODE_TXON  = 3;
    localparam int unsigned MODE_LBD   = 5;
    localparam int unsigned MODE_WUT   = 6; // 40h
    localparam int unsigned MODE_SWRST = 7;
    localparam int unsigned CAL_SKIP   = 0;
    localparam int unsigned XTAL_BUFOVR = 1;
    localparam int unsigned XTAL_BUFEN  = 0;
    // status fields
    localparam int unsigned ST_OVFL = 7;
    localparam int unsigned ST_UNFL = 6;
    localparam int unsigned ST_RXEM = 5;
    localparam int unsigned ST_HDR  = 4;
    localparam int unsigned ST_FREQ = 3;
    // power state encoding
    localparam logic [1:0] CPS_IDLE = 2'b00;
    localparam logic [1:0] CPS_RX   = 2'b01;
    localparam logic [1:0] CPS_TX   = 2'b10;

    typedef enum logic [3:0] {
        RMSM_OFF       = 4'h0,
        RMSM_POR       = 4'h1,
        RMSM_IDLE      = 4'h2,
        RMSM_XTAL      = 4'h3,
        RMSM_PLL_EN    = 4'h4,
        RMSM_VCO_CAL   = 4'h5,
        RMSM_PLL_SET   = 4'h6,
        RMSM_PA_RAMP   = 4'h7,
        RMSM_TX        = 4'h8,
        RMSM_RX_CHAIN  = 4'h9,
        RMSM_RX        = 4'ha
    } rmsm_state_t;

    typedef enum logic [2:0] {
        IDLE_STANDBY = 3'h0,
        IDLE_SLEEP   = 3'h1,
        IDLE_SENSOR  = 3'h2,
        IDLE_READY   = 3'h3,
        IDLE_TUNE    = 3'h4
    } rmsm_idle_t;

    typedef struct packed {
        logic ovfl;
        logic unfl;
        logic rx_empty;
        logic hdr_err;
        logic freq_err;
    } rmsm_modem_flags_t;

    typedef struct packed {
        logic low_power_reg;
        logic main_reg;
        logic wake_timer;
        logic low_batt_det;
        logic xtal;
        logic xtal_buf;
        logic pll;
        logic vco_cal;
        logic pa;
        logic rx_chain;
        logic modem_rx;
    } rmsm_blocks_t;
endpackage

// >>> src/rmsm_radio_mode_ctrl.sv
// radio operating-mode controller: spi register access, idle sub-modes, tx/rx sequencer
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - states shutdown, idle, transmit, receive; idle has standby, sleep, sensor, ready, tune.
// - power-off pin high forces shutdown; mode register cannot reach shutdown.
// - shutdown clears every register and ignores all spi traffic.
// - falling edge of power-off pin starts power-on reset, ending in ready.
// - power-on reset, software reset or shutdown exit default to ready.
// - mode write 0h selects standby; registers stay accessible on low-power regulator.
// - wake-timer bit 40h selects sleep with regulator and wake timer on.
// - sensor runs on the main regulator with the low-battery detector on, wake timer by its bit.
// - crystal-on bit selects ready, crystal keeps running.
// - pll-on bit selects tune; crystal enabled automatically.
// - transmit-on or receive-on bit leaves idle through automatic sequencing.
// - tx entry: regulators, crystal wait, pll, vco cal, settle, pa ramp, send.
// - rx entry: regulators, crystal wait, pll, vco cal, settle, rx chain, modem.
// - skip bit bypasses vco calibration; steps already satisfied are omitted.
// - vco and pll recalibrate each time the pll is enabled (here on each tx/rx entry or switch, not when tune turns it on).
// - entry 16.8 ms from shutdown (here 16 ms reset plus the 200 us ready path), 800 us low-power, 200 us ready/tune/switch.
// - low-power regulator only in standby and sleep; main regulator elsewhere.
// - status 02h holds fifo over/underflow, rx empty, header, frequency errors, state.
module rmsm_radio_mode_ctrl
    import rmsm_pkg::*;
#(
    parameter logic [TMR_W-1:0] POR_CYCLES       = TMR_W'(POR_CYC),
    parameter logic [TMR_W-1:0] XTAL_CYCLES      = TMR_W'(XTAL_CYC),
    parameter logic [TMR_W-1:0] VCO_CAL_CYCLES   = TMR_W'(VCO_CAL_CYC),
    parameter logic [TMR_W-1:0] PLL_SET_CYCLES   = TMR_W'(PLL_SET_CYC),
    parameter logic [TMR_W-1:0] FRONT_END_CYCLES = TMR_W'(FRONT_END_CYC)
) (
    input  wire logic              core_clk_in,        // 100 MHz core clock
    input  wire logic              srst_in,            // synchronous reset, active high
    input  wire logic              power_off_pin_in,   // high holds the radio in shutdown
    input  wire logic              spi_sck_in,         // spi clock, sampled
    input  wire logic              spi_csn_in,         // spi select, active low
    input  wire logic              spi_mosi_in,        // spi data in
    output logic                   spi_miso_out,       // spi data out
    output logic                   spi_miso_oe_n_out,  // low while miso is driven
    input  wire rmsm_modem_flags_t modem_flags_in,     // fifo and modem error levels
    input  wire logic              pkt_sent_in,        // pulse: packet transmission done
    output rmsm_blocks_t           blocks_out,         // circuit block enables
    output logic [1:0]             power_state_out     // chip power state
);

    // ------------------------------------------------------------------
    // state and registers
    // ------------------------------------------------------------------
    rmsm_state_t      state_r;
    rmsm_state_t      state_nxt;
    logic [TMR_W-1:0] tmr_r;
    logic [TMR_W-1:0] tmr_nxt;
    logic             tmr_load;
    logic             tmr_done;
    logic [7:0]       mode_r;
    logic [7:0]       cal_ctrl_r;
    logic [7:0]       xtal_ctl_r;
    logic             pin_prev_r;
    logic             alive;
    rmsm_idle_t       idle_mode;
    rmsm_blocks_t     blocks_nxt;
    logic [1:0]       cps_nxt;
    logic [7:0]       status_val;

    // spi
    logic             sck_prev_r;
    logic [3:0]       bit_cnt_r;
    logic [7:0]       shift_r;
    logic             wr_r;
    logic [6:0]       addr_r;
    logic [7:0]       miso_sh_r;
    logic             sck_rise;
    logic             sck_fall;
    logic             spi_active;
    logic             wr_strobe;
    logic [7:0]       wr_data;
    logic [7:0]       rd_data;

    // the controller and its registers exist only while powered and past reset
    assign alive      = !power_off_pin_in && (state_r != RMSM_OFF) && (state_r != RMSM_POR);
    assign spi_active = alive && !spi_csn_in;
    assign sck_rise   = spi_active && spi_sck_in && !sck_prev_r;
    assign sck_fall   = spi_active && !spi_sck_in && sck_prev_r;
    assign wr_data    = {shift_r[6:0], spi_mosi_in};
    assign wr_strobe  = sck_rise && wr_r && (bit_cnt_r == 4'hf);
    assign tmr_done   = (tmr_r == '0);

    // ------------------------------------------------------------------
    // spi slave: bit 0 r/w (1 = write), 7 address bits, 8 data bits, msb first
    // ------------------------------------------------------------------
    // framing counter; deselect always realigns to the command bit
    always_ff @(posedge core_clk_in) begin
        if (srst_in || !spi_active) begin
            bit_cnt_r <= 4'h0;
            shift_r   <= 8'h00;
            wr_r      <= 1'b0;
            addr_r    <= 7'h00;
        end else if (sck_rise) begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
            shift_r   <= wr_data;
            if (bit_cnt_r == 4'h0) begin
                wr_r <= spi_mosi_in;
            end
            if (bit_cnt_r == 4'h7) begin
                addr_r <= wr_data[6:0];
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        sck_prev_r <= !srst_in && spi_sck_in;
    end

    // read data decode; unmapped addresses read as zero
    always_comb begin
        unique case (wr_data[6:0])
            ADDR_STATUS:   rd_data = status_val;
            ADDR_MODE:     rd_data = mode_r;
            ADDR_CAL_CTRL: rd_data = cal_ctrl_r;
            ADDR_XTAL_CTL: rd_data = xtal_ctl_r;
            default:       rd_data = 8'h00;
        endcase
    end

    // miso shifts on the falling edge so it is stable at the host's rising edge
    always_ff @(posedge core_clk_in) begin
        if (srst_in || !spi_active) begin
            miso_sh_r <= 8'h00;
        end else if (sck_rise && (bit_cnt_r == 4'h7) && !wr_r) begin
            miso_sh_r <= rd_data;
        end else if (sck_fall && (bit_cnt_r > 4'h8)) begin
            miso_sh_r <= {miso_sh_r[6:0], 1'b0};
        end
    end

    assign spi_miso_out      = miso_sh_r[7];
    assign spi_miso_oe_n_out = !(spi_active && !wr_r && (bit_cnt_r >= 4'h8));

    // ------------------------------------------------------------------
    // status register
    // ------------------------------------------------------------------
    always_comb begin
        status_val          = 8'h00;
        status_val[ST_OVFL] = modem_flags_in.ovfl;
        status_val[ST_UNFL] = modem_flags_in.unfl;
        status_val[ST_RXEM] = modem_flags_in.rx_empty;
        status_val[ST_HDR]  = modem_flags_in.hdr_err;
        status_val[ST_FREQ] = modem_flags_in.freq_err;
        status_val[1:0]     = power_state_out;
    end

    // ------------------------------------------------------------------
    // writable registers
    // ------------------------------------------------------------------
    // mode control; a set reset bit restores defaults and does not stick.
    // a host write in the same cycle as a packet-done clear wins.
    always_ff @(posedge core_clk_in) begin
        if (srst_in || !alive) begin
            mode_r <= MODE_RST;
        end else if (wr_strobe && (addr_r == ADDR_MODE)) begin
            if (wr_data[MODE_SWRST]) begin
                mode_r <= MODE_RST;
            end else begin
                mode_r <= wr_data;
            end
        end else if (state_r == RMSM_TX && pkt_sent_in) begin
            mode_r[MODE_TXON] <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (srst_in || !alive) begin
            cal_ctrl_r <= CAL_CTRL_RST;
            xtal_ctl_r <= XTAL_CTL_RST;
        end else if (wr_strobe && (addr_r == ADDR_MODE) && wr_data[MODE_SWRST]) begin
            cal_ctrl_r <= CAL_CTRL_RST;
            xtal_ctl_r <= XTAL_CTL_RST;
        end else if (wr_strobe && (addr_r == ADDR_CAL_CTRL)) begin
            cal_ctrl_r <= wr_data;
        end else if (wr_strobe && (addr_r == ADDR_XTAL_CTL)) begin
            xtal_ctl_r <= wr_data;
        end
    end

    // ------------------------------------------------------------------
    // idle sub-mode decode, highest demand wins
    // ------------------------------------------------------------------
    always_comb begin
        if (mode_r[MODE_PLLON]) begin
            idle_mode = IDLE_TUNE;
        end else if (mode_r[MODE_XTON] || xtal_ctl_r[XTAL_BUFOVR]) begin
            idle_mode = IDLE_READY;
        end else if (mode_r[MODE_LBD]) begin
            idle_mode = IDLE_SENSOR;
        end else if (mode_r[MODE_WUT]) begin
            idle_mode = IDLE_SLEEP;
        end else begin
            idle_mode = IDLE_STANDBY;
        end
    end

    // ------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_in) begin
        pin_prev_r <= srst_in || power_off_pin_in; // reset reads as the idle high pin
    end

    // each wait step loads the shared timer on entry and advances at zero
    always_comb begin
        state_nxt = state_r;
        tmr_load  = 1'b0;
        tmr_nxt   = '0;
        unique case (state_r)
            RMSM_OFF: begin
                if (pin_prev_r && !power_off_pin_in) begin
                    state_nxt = RMSM_POR;
                    tmr_load  = 1'b1;
                    tmr_nxt   = POR_CYCLES;
                end
            end
            RMSM_POR, RMSM_XTAL: begin
                if (tmr_done) begin
                    state_nxt = (state_r == RMSM_POR) ? RMSM_IDLE : RMSM_PLL_EN;
                end
            end
            RMSM_IDLE: begin
                if (mode_r[MODE_TXON] || mode_r[MODE_RXON]) begin
                    if (idle_mode inside {IDLE_TUNE, IDLE_READY}) begin
                        state_nxt = RMSM_PLL_EN;
                    end else begin
                        state_nxt = RMSM_XTAL;
                        tmr_load  = 1'b1;
                        tmr_nxt   = XTAL_CYCLES;
                    end
                end
            end
            RMSM_PLL_EN: begin
                tmr_load = 1'b1;
                if (cal_ctrl_r[CAL_SKIP]) begin
                    state_nxt = RMSM_PLL_SET;
                    tmr_nxt   = PLL_SET_CYCLES;
                end else begin
                    state_nxt = RMSM_VCO_CAL;
                    tmr_nxt   = VCO_CAL_CYCLES;
                end
            end
            RMSM_VCO_CAL: begin
                if (tmr_done) begin
                    state_nxt = RMSM_PLL_SET;
                    tmr_load  = 1'b1;
                    tmr_nxt   = PLL_SET_CYCLES;
                end
            end
            RMSM_PLL_SET: begin
                if (tmr_done) begin
                    state_nxt = mode_r[MODE_TXON] ? RMSM_PA_RAMP : RMSM_RX_CHAIN;
                    tmr_load  = 1'b1;
                    tmr_nxt   = FRONT_END_CYCLES;
                end
            end
            RMSM_PA_RAMP, RMSM_RX_CHAIN: begin
                if (tmr_done) begin
                    state_nxt = (state_r == RMSM_PA_RAMP) ? RMSM_TX : RMSM_RX;
                end
            end
            RMSM_TX: begin
                if (!mode_r[MODE_TXON]) begin
                    state_nxt = mode_r[MODE_RXON] ? RMSM_PLL_EN : RMSM_IDLE;
                end
            end
            RMSM_RX: begin
                if (mode_r[MODE_TXON] || !mode_r[MODE_RXON]) begin
                    state_nxt = mode_r[MODE_TXON] ? RMSM_PLL_EN : RMSM_IDLE;
                end
            end
            default: begin
                state_nxt = RMSM_OFF;
            end
        endcase
        // a dropped request aborts any entry sequence back to idle
        if ((state_r inside {RMSM_XTAL, RMSM_PLL_EN, RMSM_VCO_CAL, RMSM_PLL_SET,
                             RMSM_PA_RAMP, RMSM_RX_CHAIN})
            && !mode_r[MODE_TXON] && !mode_r[MODE_RXON]) begin
            state_nxt = RMSM_IDLE;
            tmr_load  = 1'b0;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (srst_in || power_off_pin_in) begin
            state_r <= RMSM_OFF;
        end else if (wr_strobe && (addr_r == ADDR_MODE) && wr_data[MODE_SWRST]) begin
            state_r <= RMSM_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (srst_in || power_off_pin_in) begin
            tmr_r <= '0;
        end else if (tmr_load) begin
            tmr_r <= tmr_nxt;
        end else if (!tmr_done) begin
            tmr_r <= tmr_r - TMR_W'(1);
        end
    end

    // ------------------------------------------------------------------
    // block enables and power state, registered before leaving the block
    // ------------------------------------------------------------------
    always_comb begin
        blocks_nxt = '0;
        cps_nxt    = CPS_IDLE;
        if (state_r == RMSM_IDLE) begin
            blocks_nxt.low_power_reg = idle_mode inside {IDLE_STANDBY, IDLE_SLEEP};
            blocks_nxt.main_reg      = !(idle_mode inside {IDLE_STANDBY, IDLE_SLEEP});
            blocks_nxt.wake_timer    = mode_r[MODE_WUT];
            blocks_nxt.low_batt_det  = mode_r[MODE_LBD];
            blocks_nxt.xtal          = idle_mode inside {IDLE_READY, IDLE_TUNE};
            blocks_nxt.xtal_buf      = blocks_nxt.xtal && xtal_ctl_r[XTAL_BUFEN] == 1'b0;
            blocks_nxt.pll           = (idle_mode == IDLE_TUNE);
        end else if (state_r != RMSM_OFF && state_r != RMSM_POR) begin
            // every sequencing or active state runs on the main regulator
            blocks_nxt.main_reg      = 1'b1;
            blocks_nxt.wake_timer    = mode_r[MODE_WUT];
            blocks_nxt.low_batt_det  = mode_r[MODE_LBD];
            blocks_nxt.xtal          = 1'b1;
            blocks_nxt.xtal_buf      = 1'b1;
            blocks_nxt.pll           = (state_r != RMSM_XTAL);
            blocks_nxt.vco_cal       = (state_r == RMSM_VCO_CAL);
            blocks_nxt.pa            = state_r inside {RMSM_PA_RAMP, RMSM_TX};
            blocks_nxt.rx_chain      = state_r inside {RMSM_RX_CHAIN, RMSM_RX};
            blocks_nxt.modem_rx      = (state_r == RMSM_RX);
            if (state_r == RMSM_TX) begin
                cps_nxt = CPS_TX;
            end else if (state_r == RMSM_RX) begin
                cps_nxt = CPS_RX;
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            blocks_out      <= '0;
            power_state_out <= CPS_IDLE;
        end else begin
            blocks_out      <= blocks_nxt;
            power_state_out <= cps_nxt;
        end
    end

endmodule

`default_nettype wire

// >>> tb/rmsm_sva.sv
// checker of the radio mode controller outputs, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module rmsm_sva
    import rmsm_pkg::*;
#(
    parameter logic [TMR_W-1:0] POR_CYCLES = TMR_W'(POR_CYC)
) (
    input wire logic         core_clk_in,       // core clock
    input wire logic         srst_in,           // synchronous reset
    input wire logic         power_off_pin_in,  // shutdown pin
    input wire logic         spi_miso_oe_n_out, // low while miso driven
    input wire rmsm_blocks_t blocks_out,        // block enables
    input wire logic [1:0]   power_state_out    // chip power state
);
    // ------------------------------------------------------------------
    // sequences and properties
    // ------------------------------------------------------------------
    // margin covers the pin sampling and the registered block outputs
    localparam int POR_HI = int'(POR_CYCLES) + 6;
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (srst_in);
    sequence off_held; power_off_pin_in [*3]; endsequence
    sequence por_start; $fell(power_off_pin_in); endsequence
    sequence tx_held; (power_state_out == CPS_TX) [*2]; endsequence
    sequence rx_held; (power_state_out == CPS_RX) [*2]; endsequence
    chk_off_blocks: assert property (
        off_held |-> blocks_out == '0 && power_state_out == CPS_IDLE)
        else $error("blocks active in shutdown");
    chk_off_miso: assert property (off_held |-> spi_miso_oe_n_out)
        else $error("miso driven in shutdown");
    chk_por_ready: assert property (por_start |-> ##[1:POR_HI] blocks_out.xtal)
        else $error("no ready mode after power-on reset");
    chk_tx_blocks: assert property (
        tx_held |-> blocks_out.pa && blocks_out.pll && blocks_out.xtal && blocks_out.main_reg)
        else $error("transmit without its blocks");
    chk_rx_blocks: assert property (
        rx_held |-> blocks_out.rx_chain && blocks_out.modem_rx && !blocks_out.pa)
        else $error("receive without its blocks");
    chk_lp_only: assert property (
        blocks_out.low_power_reg |-> !blocks_out.main_reg && !blocks_out.xtal)
        else $error("low power regulator outside standby or sleep");
    chk_pll_xtal: assert property (blocks_out.pll |-> blocks_out.xtal)
        else $error("pll on without crystal");
    chk_ps_code: assert property (power_state_out != 2'b11)
        else $error("undefined power state code");
endmodule
bind rmsm_radio_mode_ctrl rmsm_sva #(.POR_CYCLES(POR_CYCLES)) u_rmsm_sva (
    .core_clk_in(core_clk_in), .srst_in(srst_in), .power_off_pin_in(power_off_pin_in),
    .spi_miso_oe_n_out(spi_miso_oe_n_out), .blocks_out(blocks_out),
    .power_state_out(power_state_out));
`default_nettype wire

// >>> tb/rmsm_host_model.sv
// host microcontroller model: power-off pin and spi master
`timescale 1ns/1ps
`default_nettype none
module rmsm_host_model (
    input  wire logic core_clk_in,       // core clock, host steps on its falling edge
    input  wire logic spi_miso_in,       // resolved miso line
    output logic      power_off_pin_out, // shutdown request
    output logic      spi_sck_out,       // spi clock, idles low
    output logic      spi_csn_out,       // spi select, active low
    output logic      spi_mosi_out       // spi data to radio
);
    // no interrupt, crystal buffer or adc routing access is ever made
    initial begin
        power_off_pin_out = 1'b1;
        spi_sck_out = 1'b0;
        spi_csn_out = 1'b1;
        spi_mosi_out = 1'b0;
    end
    task automatic step(input int n);
        repeat (n) @(negedge core_clk_in);
    endtask
    // pin stays low outside shutdown
    task automatic set_pin(input logic v);
        power_off_pin_out <= v;
        step(1);
    endtask
    // whole frame, four core cycles low and three high per sck phase keeps the two-cycle minimum
    task automatic xfer(input logic wr, input logic [6:0] a, input logic [7:0] d,
                        output logic [7:0] q);
        logic [15:0] f;
        f = {wr, a, d};
        q = 8'h00;
        spi_csn_out <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            step(1);
            spi_mosi_out <= f[i];
            step(3);
            if (i <= 7) q[i] = spi_miso_in; // data bits sampled as sck rises
            spi_sck_out <= 1'b1;
            step(3);
            spi_sck_out <= 1'b0;
        end
        step(3);
        spi_csn_out <= 1'b1;
        spi_mosi_out <= ~f[0]; // released line does not keep the last bit
        step(3);
    endtask
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// self-checking testbench of the radio mode controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin errors++; \
    $display("unexpected at %0t: got %0h want %0h", $time, (a), (b)); end end
module tb_top;
    import rmsm_pkg::*;
    logic core_clk_in = 1'b0, srst_in = 1'b1, pkt_sent_in = 1'b0;
    logic pin, sck, csn, mosi, miso, oe_n, miso_w;
    logic [1:0] ps;
    logic [7:0] q;
    rmsm_blocks_t blk;
    rmsm_modem_flags_t flags = 5'h15;
    int errors = 0, num_checks = 0, c0, c1, c2, c3;
    logic [7:0] modes [5] = '{8'h00, 8'h40, 8'h60, 8'h01, 8'h02};
    logic [5:0] exp_blk [5] = '{6'b100000, 6'b101000, 6'b011100, 6'b010010, 6'b010011};
    assign miso_w = oe_n ? ~miso : miso; // no pull: an undriven line shows a wrong level
    always #5 core_clk_in = ~core_clk_in;
    rmsm_radio_mode_ctrl #(.POR_CYCLES(TMR_W'(20)), .XTAL_CYCLES(TMR_W'(10)),
        .VCO_CAL_CYCLES(TMR_W'(5)), .PLL_SET_CYCLES(TMR_W'(5)), .FRONT_END_CYCLES(TMR_W'(3)))
    u_rmsm_radio_mode_ctrl (.core_clk_in(core_clk_in), .srst_in(srst_in),
        .power_off_pin_in(pin), .spi_sck_in(sck), .spi_csn_in(csn), .spi_mosi_in(mosi),
        .spi_miso_out(miso), .spi_miso_oe_n_out(oe_n), .modem_flags_in(flags),
        .pkt_sent_in(pkt_sent_in), .blocks_out(blk), .power_state_out(ps));
    rmsm_host_model u_rmsm_host_model (.core_clk_in(core_clk_in), .spi_miso_in(miso_w),
        .power_off_pin_out(pin), .spi_sck_out(sck), .spi_csn_out(csn), .spi_mosi_out(mosi));
    // ------------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------------
    task automatic rd(input logic [6:0] a);
        u_rmsm_host_model.xfer(1'b0, a, 8'h00, q);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        u_rmsm_host_model.xfer(1'b1, a, d, q);
    endtask
    // counts cycles from the end of the mode write to the target state
    task automatic go(input logic [7:0] m, input logic [1:0] st, output int n);
        wr(ADDR_MODE, m);
        n = 0;
        while (ps !== st && n < 500) begin
            @(negedge core_clk_in);
            n++;
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // watchdog: the whole run needs about a tenth of this span
    initial begin
        #500000;
        errors++;
        finish_test();
    end
    // main sequence
    initial begin
        repeat (20) @(negedge core_clk_in);
        srst_in <= 1'b0;
        u_rmsm_host_model.set_pin(1'b0);
        repeat (40) @(negedge core_clk_in);
        rd(ADDR_MODE); `CHK(q, MODE_RST)
        wr(ADDR_STATUS, 8'hff); rd(ADDR_STATUS); `CHK(q, {flags, 1'b0, CPS_IDLE})
        rd(7'h3c); `CHK(q, 8'h00)
        $display("test reset_status done");
        for (int i = 0; i < 5; i++) begin
            wr(ADDR_MODE, modes[i]);
            `CHK({blk.low_power_reg, blk.main_reg, blk.wake_timer, blk.low_batt_det, blk.xtal, blk.pll}, exp_blk[i])
            rd(ADDR_MODE); `CHK(q, modes[i])
        end
        $display("test idle_modes done");
        wr(ADDR_MODE, MODE_RST);
        go(8'h09, CPS_TX, c0); `CHK(ps, CPS_TX)
        @(negedge core_clk_in) pkt_sent_in <= 1'b1;
        @(negedge core_clk_in) pkt_sent_in <= 1'b0;
        rd(ADDR_MODE); `CHK(q, 8'h01)
        go(8'h09, CPS_TX, c1); `CHK(c1, c0)
        go(8'h05, CPS_RX, c2); `CHK(c2, c0)
        // a timed step holds its load count plus the cycle that leaves it
        wr(ADDR_MODE, 8'h00); go(8'h08, CPS_TX, c2); `CHK(c2, c0 + 11)
        wr(ADDR_MODE, 8'h01); wr(ADDR_CAL_CTRL, 8'h01);
        go(8'h09, CPS_TX, c3); `CHK(c3, c0 - 6)
        $display("test sequencer done");
        u_rmsm_host_model.set_pin(1'b1);
        wr(ADDR_MODE, 8'h00); `CHK(ps, CPS_IDLE)
        u_rmsm_host_model.set_pin(1'b0);
        repeat (40) @(negedge core_clk_in);
        rd(ADDR_CAL_CTRL); `CHK(q, CAL_CTRL_RST)
        rd(ADDR_MODE); `CHK(q, MODE_RST)
        wr(ADDR_CAL_CTRL, 8'h01); wr(ADDR_MODE, 8'h80);
        rd(ADDR_CAL_CTRL); `CHK(q, CAL_CTRL_RST)
        $display("test shutdown_reset done");
        finish_test();
    end
endmodule
`default_nettype wire
